/* File: hdl/seg_addr_unit.sv */
// What this block does
// - Physical address is segment times sixteen plus offset.
// - Segment and offset are both unsigned.
// - Physical addresses are twenty bits wide.
// - Fetches use code segment and fetch pointer.
// - Code segment override redirects data operand.
// - Stack accesses use stack segment and top pointer.
// - Base pointer base defaults to stack segment.
// - Data defaults data segment 0; block source uses index.
// - Data 0 override replaces stack default.
// - Block destination uses data segment 1, destination index.
// - Counter advances to the next instruction.
// - Direct branch loads immediates; far loads code segment.
// - Relative branch adds sign-extended displacement.
// - Relative base is the following instruction address.
// - Register branch loads counter from selected register.
// - Register-indirect branch reads through index or base.
// - Indexed branch: index plus displacement addresses target.
// - Based branch: base plus displacement addresses target.
// - Based-indexed: displacement, base, index sum.
// - Register field with size bit picks register.
// - Segment field picks one of four segments.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ns
module seg_addr_unit (
   input  wire logic                            CLK,
   input  wire logic                            RST,
   input  wire logic                            PSEL,
   input  wire logic                            PENABLE,
   input  wire logic                            PWRITE,
   input  wire logic [addr_gen_pkg::APB_AW-1:0] PADDR,
   input  wire logic [31:0]                     PWDATA,
   output logic      [31:0]                     PRDATA,
   output logic                                 PREADY,
   output logic                                 PSLVERR,
   output logic      [addr_gen_pkg::PA_W-1:0]   FETCH_ADDR
);
   import addr_gen_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Storage.
   logic [NUM_GP-1:0][WORD_W-1:0]  gp_word;
   logic [NUM_SEG-1:0][WORD_W-1:0] seg_word;
   logic [WORD_W-1:0]              instr_counter;
   logic [WORD_W-1:0]              fetch_offset_ptr;
   logic [31:0]                    access_reg;
   logic [31:0]                    operand_reg;
   logic [31:0]                    branch_reg;
   logic [31:0]                    imm_reg;
   logic [31:0]                    mem_data_reg;
   logic [31:0]                    reg_sel_reg;
   logic [31:0]                    prdata_reg;
   logic                           ready_reg;
   logic                           err_reg;
   logic [PA_W-1:0]                fetch_addr_reg;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Named views of the register file.
   logic [WORD_W-1:0] code_segment_reg;
   logic [WORD_W-1:0] stack_top_ptr;
   logic [WORD_W-1:0] base_pointer_reg;
   logic [WORD_W-1:0] base_word_reg;
   logic [WORD_W-1:0] source_index_reg;
   logic [WORD_W-1:0] dest_index_reg;

   assign code_segment_reg = seg_word[SEG_CODE];
   assign stack_top_ptr    = gp_word[IDX_SP];
   assign base_pointer_reg = gp_word[IDX_BP];
   assign base_word_reg    = gp_word[IDX_BW];
   assign source_index_reg = gp_word[IDX_IX];
   assign dest_index_reg   = gp_word[IDX_IY];

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // APB slave. One wait state lets read data come straight from a flip-flop.
   logic addr_ok;
   logic access_phase;
   logic wr_en;
   logic [31:0] rd_val;

   assign addr_ok      = (PADDR[1:0] == 2'h0) && (PADDR <= OFF_LAST);
   assign access_phase = PSEL & PENABLE;
   assign wr_en        = access_phase & ready_reg & PWRITE & ~err_reg;
   assign PREADY       = ready_reg;
   assign PSLVERR      = ready_reg & err_reg;
   assign PRDATA       = prdata_reg;
   assign FETCH_ADDR   = fetch_addr_reg;

   logic hit_instr;
   logic hit_fetch;
   logic hit_advance;
   logic br_go;

   assign hit_instr   = wr_en && (PADDR == OFF_INSTR_CNT);
   assign hit_fetch   = wr_en && (PADDR == OFF_FETCH_PTR);
   assign hit_advance = wr_en && (PADDR == OFF_ADVANCE);
   assign br_go       = wr_en && (PADDR == OFF_BR_GO);

   always_ff @(posedge CLK) begin
      if (RST) begin
         ready_reg  <= 1'b0;
         err_reg    <= 1'b0;
         prdata_reg <= RST_CTL;
      end else begin
         ready_reg <= access_phase & ~ready_reg;
         if (access_phase && !ready_reg) begin
            err_reg    <= ~addr_ok;
            prdata_reg <= (PWRITE || !addr_ok) ? RST_CTL : rd_val;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Control registers written straight from the bus.
   always_ff @(posedge CLK) begin
      if (RST) begin
         access_reg   <= RST_CTL;
         operand_reg  <= RST_CTL;
         branch_reg   <= RST_CTL;
         imm_reg      <= RST_CTL;
         mem_data_reg <= RST_CTL;
         reg_sel_reg  <= RST_CTL;
      end else if (wr_en) begin
         if (PADDR == OFF_ACCESS)   access_reg   <= PWDATA;
         if (PADDR == OFF_OPERAND)  operand_reg  <= PWDATA;
         if (PADDR == OFF_BRANCH)   branch_reg   <= PWDATA;
         if (PADDR == OFF_IMM)      imm_reg      <= PWDATA;
         if (PADDR == OFF_MEM_DATA) mem_data_reg <= PWDATA;
         if (PADDR == OFF_REG_SEL)  reg_sel_reg  <= PWDATA;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Effective address from the operand descriptor.
   logic [WORD_W-1:0] disp_raw;
   logic [WORD_W-1:0] disp_ext;
   logic [1:0]        base_code;
   logic [1:0]        index_code;
   logic [WORD_W-1:0] base_val;
   logic [WORD_W-1:0] index_val;
   logic [WORD_W-1:0] opd_ea;
   logic              base_is_bp;

   assign disp_raw   = operand_reg[OPD_DISP_LSB +: WORD_W];
   assign disp_ext   = operand_reg[OPD_DISP8_BIT] ? {{8{disp_raw[7]}}, disp_raw[7:0]} : disp_raw;
   assign base_code  = operand_reg[OPD_BASE_LSB +: 2];
   assign index_code = operand_reg[OPD_INDEX_LSB +: 2];
   assign base_is_bp = (base_code == BASE_BP);
   assign base_val   = (base_code == BASE_BW) ? base_word_reg : base_is_bp ? base_pointer_reg : RST_WORD;
   assign index_val  = (index_code == INDEX_IX) ? source_index_reg :
                       (index_code == INDEX_IY) ? dest_index_reg : RST_WORD;
   // Offsets wrap inside the 64 Kbyte segment, as a 16-bit adder would.
   assign opd_ea     = base_val + index_val + disp_ext;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Segment and offset choice for the configured access.
   access_kind_t      acc_kind;
   logic              ovr_en;
   logic [1:0]        ovr_seg;
   logic [1:0]        acc_seg_idx;
   logic [WORD_W-1:0] acc_off;
   logic [PA_W-1:0]   acc_phys;
   logic [PA_W-1:0]   fetch_phys;

   assign acc_kind = access_kind_t'(access_reg[ACC_KIND_LSB +: 3]);
   assign ovr_en   = access_reg[ACC_OVR_EN_BIT];
   assign ovr_seg  = access_reg[ACC_OVR_SEG_LSB +: 2];

   always_comb begin
      acc_seg_idx = SEG_CODE;
      acc_off     = fetch_offset_ptr;
      unique case (acc_kind)
         ACC_FETCH: begin
            acc_seg_idx = SEG_CODE;
            acc_off     = fetch_offset_ptr;
         end
         ACC_STACK: begin
            acc_seg_idx = SEG_STACK;
            acc_off     = stack_top_ptr;
         end
         ACC_DATA: begin
            acc_seg_idx = ovr_en ? ovr_seg : base_is_bp ? SEG_STACK : SEG_DATA0;
            acc_off     = opd_ea;
         end
         ACC_BLK_SRC: begin
            acc_seg_idx = ovr_en ? ovr_seg : SEG_DATA0;
            acc_off     = source_index_reg;
         end
         ACC_BLK_DST: begin
            // The destination block has no override path.
            acc_seg_idx = SEG_DATA1;
            acc_off     = dest_index_reg;
         end
         default: begin
            acc_seg_idx = SEG_CODE;
            acc_off     = fetch_offset_ptr;
         end
      endcase
   end

   phys_addr_calc u_acc_addr (
      .seg    (seg_word[acc_seg_idx]),
      .offset (acc_off),
      .phys   (acc_phys)
   );

   phys_addr_calc u_fetch_addr (
      .seg    (code_segment_reg),
      .offset (fetch_offset_ptr),
      .phys   (fetch_phys)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Register operand selection.
   logic [WORD_W-1:0] sel_value;
   logic [WORD_W-1:0] br_reg_word;
   logic [1:0]        sel_sreg;

   assign sel_sreg = reg_sel_reg[SEL_SREG_LSB +: 2];

   reg_select u_sel_reg (
      .regs  (gp_word),
      .field (reg_sel_reg[SEL_REG_LSB +: 3]),
      .word  (reg_sel_reg[SEL_W_BIT]),
      .value (sel_value)
   );

   reg_select u_br_reg (
      .regs  (gp_word),
      .field (branch_reg[BR_REG_LSB +: 3]),
      .word  (1'b1),
      .value (br_reg_word)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Branch target formation.
   branch_mode_t      br_mode;
   logic              br_far;
   logic [WORD_W-1:0] br_ea;
   logic [1:0]        br_seg_idx;
   logic [PA_W-1:0]   br_phys;
   logic [WORD_W-1:0] br_pc_next;
   logic [WORD_W-1:0] br_seg_next;
   logic              br_load_seg;
   logic              br_valid;

   assign br_mode    = branch_mode_t'(branch_reg[BR_MODE_LSB +: 3]);
   assign br_far     = branch_reg[BR_FAR_BIT];
   // Register-indirect pointers are meant to come from the source index, destination index or base word.
   assign br_ea      = (br_mode == BR_REG_INDIRECT) ? br_reg_word : opd_ea;
   assign br_seg_idx = ovr_en ? ovr_seg : (base_is_bp && br_mode != BR_REG_INDIRECT) ? SEG_STACK : SEG_DATA0;

   phys_addr_calc u_br_addr (
      .seg    (seg_word[br_seg_idx]),
      .offset (br_ea),
      .phys   (br_phys)
   );

   always_comb begin
      br_pc_next  = instr_counter;
      br_seg_next = code_segment_reg;
      br_load_seg = 1'b0;
      br_valid    = 1'b1;
      unique case (br_mode)
         BR_DIRECT: begin
            br_pc_next  = imm_reg[WORD_W-1:0];
            br_seg_next = imm_reg[31:WORD_W];
            br_load_seg = br_far;
         end
         BR_RELATIVE: begin
            // The counter was already advanced past the branch when this adds.
            br_pc_next = instr_counter + disp_ext;
         end
         BR_REGISTER: begin
            br_pc_next = br_reg_word;
         end
         BR_REG_INDIRECT, BR_INDEXED, BR_BASED, BR_BASED_INDEXED: begin
            // The word read at br_phys is supplied by software in the memory data register.
            br_pc_next  = mem_data_reg[WORD_W-1:0];
            br_seg_next = mem_data_reg[31:WORD_W];
            br_load_seg = br_far;
         end
         default: begin
            br_valid = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // General and segment registers.
   genvar g;
   generate
      for (g = 0; g < NUM_GP; g++) begin : g_gp
         localparam logic [7:0] OFF = OFF_GP0 + 8'(4 * g);
         logic [WORD_W-1:0] q_reg;
         always_ff @(posedge CLK) begin
            if (RST) q_reg <= RST_WORD;
            else if (wr_en && PADDR == OFF) q_reg <= PWDATA[WORD_W-1:0];
         end
         assign gp_word[g] = q_reg;
      end
      for (g = 0; g < NUM_SEG; g++) begin : g_seg
         localparam logic [7:0] OFF = OFF_SEG0 + 8'(4 * g);
         logic [WORD_W-1:0] q_reg;
         always_ff @(posedge CLK) begin
            if (RST) q_reg <= RST_WORD;
            else if (wr_en && PADDR == OFF) q_reg <= PWDATA[WORD_W-1:0];
            else if (g == SEG_CODE && br_go && br_valid && br_load_seg) q_reg <= br_seg_next;
         end
         assign seg_word[g] = q_reg;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Counter and fetch pointer.
   always_ff @(posedge CLK) begin
      if (RST) begin
         instr_counter    <= RST_WORD;
         fetch_offset_ptr <= RST_WORD;
         fetch_addr_reg   <= '0;
      end else begin
         if (hit_instr) instr_counter <= PWDATA[WORD_W-1:0];
         else if (br_go && br_valid) instr_counter <= br_pc_next;
         else if (hit_advance) instr_counter <= instr_counter + {12'h000, PWDATA[ADV_LEN_LSB +: ADV_LEN_W]};
         if (hit_fetch) fetch_offset_ptr <= PWDATA[WORD_W-1:0];
         fetch_addr_reg <= fetch_phys;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Read multiplexer.

   always_comb begin
      rd_val = RST_CTL;
      if (PADDR < OFF_SEG0) rd_val = {16'h0000, gp_word[PADDR[4:2]]};
      else if (PADDR < OFF_INSTR_CNT) rd_val = {16'h0000, seg_word[PADDR[3:2]]};
      else begin
         case (PADDR)
            OFF_INSTR_CNT:  rd_val = {16'h0000, instr_counter};
            OFF_FETCH_PTR:  rd_val = {16'h0000, fetch_offset_ptr};
            OFF_ACCESS:     rd_val = access_reg;
            OFF_OPERAND:    rd_val = operand_reg;
            OFF_ACC_ADDR:   rd_val = {12'h000, acc_phys};
            OFF_ACC_SEGOFF: rd_val = {seg_word[acc_seg_idx], acc_off};
            OFF_BRANCH:     rd_val = branch_reg;
            OFF_IMM:        rd_val = imm_reg;
            OFF_MEM_DATA:   rd_val = mem_data_reg;
            OFF_BR_ADDR:    rd_val = {12'h000, br_phys};
            OFF_REG_SEL:    rd_val = reg_sel_reg;
            OFF_SEL_VAL:    rd_val = {seg_word[sel_sreg], sel_value};
            default:        rd_val = RST_CTL;
         endcase
      end
   end

endmodule // seg_addr_unit

/* File: inc/addr_gen_pkg.sv */
package addr_gen_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Widths of the address path.
   localparam int APB_AW    = 8;
   localparam int WORD_W    = 16;
   localparam int PA_W      = 20;
   localparam int SEG_SHIFT = 4;
   localparam int NUM_GP    = 8;
   localparam int NUM_SEG   = 4;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Register byte offsets. General registers follow OFF_GP0 four bytes apart, segment registers OFF_SEG0.
   localparam logic [7:0] OFF_GP0        = 8'h00;
   localparam logic [7:0] OFF_SEG0       = 8'h20;
   localparam logic [7:0] OFF_INSTR_CNT  = 8'h30;
   localparam logic [7:0] OFF_FETCH_PTR  = 8'h34;
   localparam logic [7:0] OFF_ACCESS     = 8'h38;
   localparam logic [7:0] OFF_OPERAND    = 8'h3c;
   localparam logic [7:0] OFF_ACC_ADDR   = 8'h40;
   localparam logic [7:0] OFF_ACC_SEGOFF = 8'h44;
   localparam logic [7:0] OFF_BRANCH     = 8'h48;
   localparam logic [7:0] OFF_IMM        = 8'h4c;
   localparam logic [7:0] OFF_MEM_DATA   = 8'h50;
   localparam logic [7:0] OFF_BR_ADDR    = 8'h54;
   localparam logic [7:0] OFF_ADVANCE    = 8'h58;
   localparam logic [7:0] OFF_REG_SEL    = 8'h5c;
   localparam logic [7:0] OFF_SEL_VAL    = 8'h60;
   localparam logic [7:0] OFF_BR_GO      = 8'h64;
   localparam logic [7:0] OFF_LAST       = 8'h64;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Register field codes.
   localparam logic [2:0] IDX_BW = 3'h3;
   localparam logic [2:0] IDX_SP = 3'h4;
   localparam logic [2:0] IDX_BP = 3'h5;
   localparam logic [2:0] IDX_IX = 3'h6;
   localparam logic [2:0] IDX_IY = 3'h7;

   localparam logic [1:0] SEG_CODE  = 2'h0;
   localparam logic [1:0] SEG_STACK = 2'h1;
   localparam logic [1:0] SEG_DATA0 = 2'h2;
   localparam logic [1:0] SEG_DATA1 = 2'h3;

   localparam logic [1:0] BASE_BW  = 2'h1;
   localparam logic [1:0] BASE_BP  = 2'h2;
   localparam logic [1:0] INDEX_IX = 2'h1;
   localparam logic [1:0] INDEX_IY = 2'h2;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Field positions.
   localparam int ACC_KIND_LSB    = 0;
   localparam int ACC_OVR_EN_BIT  = 3;
   localparam int ACC_OVR_SEG_LSB = 4;
   localparam int OPD_DISP_LSB    = 0;
   localparam int OPD_BASE_LSB    = 16;
   localparam int OPD_INDEX_LSB   = 18;
   localparam int OPD_DISP8_BIT   = 20;
   localparam int BR_MODE_LSB     = 0;
   localparam int BR_FAR_BIT      = 3;
   localparam int BR_REG_LSB      = 4;
   localparam int ADV_LEN_LSB     = 0;
   localparam int ADV_LEN_W       = 4;
   localparam int SEL_REG_LSB     = 0;
   localparam int SEL_W_BIT       = 3;
   localparam int SEL_SREG_LSB    = 4;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Reset values.
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [31:0] RST_CTL  = 32'h0000_0000;

   typedef enum logic [2:0] {ACC_FETCH, ACC_STACK, ACC_DATA, ACC_BLK_SRC, ACC_BLK_DST} access_kind_t;
   typedef enum logic [2:0] {BR_DIRECT, BR_RELATIVE, BR_REGISTER, BR_REG_INDIRECT, BR_INDEXED, BR_BASED,
                             BR_BASED_INDEXED} branch_mode_t;

endpackage

/* File: hdl/phys_addr_calc.sv */
`timescale 1ns/1ns
module phys_addr_calc #(
   parameter int SEG_W = addr_gen_pkg::WORD_W,
   parameter int OFF_W = addr_gen_pkg::WORD_W,
   parameter int PA_W  = addr_gen_pkg::PA_W,
   parameter int SHIFT = addr_gen_pkg::SEG_SHIFT
) (
   input  wire logic [SEG_W-1:0] seg,
   input  wire logic [OFF_W-1:0] offset,
   output logic      [PA_W-1:0]  phys
);
   import addr_gen_pkg::*;

   logic [SEG_W+SHIFT:0] sum;

   // Both operands are zero extended, so neither is ever read as negative.
   assign sum  = {1'b0, seg, {SHIFT{1'b0}}} + {{(SEG_W+SHIFT+1-OFF_W){1'b0}}, offset};
   // The carry out of the top address bit is dropped, so the space wraps.
   assign phys = sum[PA_W-1:0];

endmodule // phys_addr_calc

/* File: hdl/reg_select.sv */
`timescale 1ns/1ns
module reg_select #(
   parameter int W = addr_gen_pkg::WORD_W,
   parameter int N = addr_gen_pkg::NUM_GP
) (
   input  wire logic [N-1:0][W-1:0]   regs,
   input  wire logic [$clog2(N)-1:0]  field,
   input  wire logic                  word,
   output logic      [W-1:0]          value
);
   import addr_gen_pkg::*;

   localparam int HB = W / 2;

   logic [W-1:0]  byte_src;
   logic [HB-1:0] byte_val;

   // Byte codes pick the low half of the first four words, then their high halves.
   assign byte_src = regs[field[$clog2(N)-2:0]];
   assign byte_val = field[$clog2(N)-1] ? byte_src[W-1:HB] : byte_src[HB-1:0];
   assign value    = word ? regs[field] : {{(W-HB){1'b0}}, byte_val};

endmodule // reg_select

/* File: verif/seg_addr_checker.sv */
`timescale 1ns/1ns
module seg_addr_checker
   import addr_gen_pkg::*;
(
   input wire logic              CLK,
   input wire logic              RST,
   input wire logic              PSEL,
   input wire logic              PENABLE,
   input wire logic              PWRITE,
   input wire logic [APB_AW-1:0] PADDR,
   input wire logic [31:0]       PWDATA,
   input wire logic [31:0]       PRDATA,
   input wire logic              PREADY,
   input wire logic              PSLVERR,
   input wire logic [PA_W-1:0]   FETCH_ADDR
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);

   ////////////////////////////////////////////////////////////////////////////////
   logic        done;
   logic        wr_done;
   logic        fetch_wr;
   logic [15:0] fp_reg;
   logic        selw_reg;
   assign done     = PSEL && PENABLE && PREADY;
   assign wr_done  = done && PWRITE && !PSLVERR;
   assign fetch_wr = wr_done && (PADDR == OFF_SEG0 || PADDR == OFF_FETCH_PTR || PADDR == OFF_BR_GO);

   // Shadows follow only completed writes, so a refused access never moves them.
   always_ff @(posedge CLK) begin
      if (RST) begin
         fp_reg   <= 16'h0000;
         selw_reg <= 1'b0;
      end else if (wr_done && PADDR == OFF_FETCH_PTR) begin
         fp_reg <= PWDATA[15:0];
      end else if (wr_done && PADDR == OFF_REG_SEL) begin
         selw_reg <= PWDATA[SEL_W_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   a_one_wait: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY) else $error("wait state count wrong");
   a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready longer than one cycle");
   a_err_decode: assert property (done |-> PSLVERR == (PADDR[1:0] != 2'h0 || PADDR > OFF_LAST))
      else $error("error flag decode wrong");
   a_fetch_hold: assert property (!$stable(FETCH_ADDR) |-> $past(fetch_wr, 2))
      else $error("fetch address moved without cause");
   a_fetch_nibble: assert property (FETCH_ADDR[3:0] == $past(fp_reg[3:0]))
      else $error("fetch address low nibble not offset");
   a_phys_width: assert property (done && !PWRITE && (PADDR == OFF_ACC_ADDR || PADDR == OFF_BR_ADDR)
      |-> PRDATA[31:20] == 12'h000) else $error("physical address too wide");
   a_word_upper: assert property (done && !PWRITE && PADDR < OFF_ACCESS && !PSLVERR
      |-> PRDATA[31:16] == 16'h0000) else $error("word register upper half not zero");
   a_byte_zext: assert property (done && !PWRITE && PADDR == OFF_SEL_VAL && !selw_reg
      |-> PRDATA[15:8] == 8'h00) else $error("byte register not zero extended");

   c_error: cover property (done && PSLVERR);
   c_branch: cover property (wr_done && PADDR == OFF_BR_GO);
   c_fetch_move: cover property (!$stable(FETCH_ADDR));
endmodule // seg_addr_checker

bind seg_addr_unit seg_addr_checker seg_addr_checker_inst (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
   .PWDATA, .PRDATA, .PREADY, .PSLVERR, .FETCH_ADDR);

/* File: verif/tb.sv */
`timescale 1ns/1ns
module tb;
   import addr_gen_pkg::*;
   logic              CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er;
   logic [APB_AW-1:0] PADDR;
   logic [31:0]       PWDATA, PRDATA, rd;
   logic [PA_W-1:0]   FETCH_ADDR;
   int                num_errors, checks;
   localparam logic [15:0] SEG [4] = '{16'h1000, 16'h2000, 16'h3000, 16'h4000};
   localparam logic [15:0] GP [8]  = '{16'h1234, 16'h0, 16'h0, 16'h0100, 16'h0200, 16'h0300, 16'h0400, 16'h0500};
   localparam logic [31:0] ACC [8] = '{32'h0, 32'h1, 32'h2, 32'h2a, 32'h0a, 32'h2, 32'h3, 32'h4};
   localparam logic [31:0] OPD [8] = '{32'h0, 32'h0, 32'h20010, 32'h20010, 32'h10010, 32'h10010, 32'h0, 32'h0};
   localparam logic [31:0] PHY [8] = '{32'h10025, 32'h20200, 32'h20310, 32'h30310, 32'h10110, 32'h30110,
                                       32'h30400, 32'h40500};
   localparam logic [31:0] BRM [4] = '{32'h63, 32'h04, 32'h05, 32'h06};
   localparam logic [31:0] BOP [4] = '{32'h0, 32'h40004, 32'h20002, 32'h90008};
   localparam logic [31:0] BPA [4] = '{32'h30400, 32'h30404, 32'h20302, 32'h30608};

   seg_addr_unit seg_addr_unit_inst (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
      .PSLVERR, .FETCH_ADDR);

   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         num_errors++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask

   // Every transfer starts one edge after the last release, so no signal gets two drives in one step.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge CLK);
      PSEL <= 1'b1; PWRITE <= w; PADDR <= a; PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      n = 0;
      do begin @(posedge CLK); n++; end while (PREADY !== 1'b1 && n < 20);
      if (PREADY !== 1'b1) begin num_errors++; finish_test(); end
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0; PENABLE <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(nm, rd, e);
   endtask

   task automatic go;
      wr(OFF_BR_GO, 32'h0);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end

   initial begin
      RST = 1'b1; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0; PADDR = 8'h00; PWDATA = 32'h0;
      num_errors = 0; checks = 0;
      repeat (20) @(posedge CLK);
      RST <= 1'b0;
      rdc("cnt_rst", OFF_INSTR_CNT, 32'h0);
      wr(OFF_SEG0, 32'hffff); wr(OFF_FETCH_PTR, 32'h25);
      repeat (2) @(posedge CLK);
      chk("fetch_wrap", {12'h0, FETCH_ADDR}, 32'h15);
      for (int i = 0; i < 4; i++) wr(OFF_SEG0 + 8'(4 * i), {16'h0, SEG[i]});
      for (int i = 0; i < 8; i++) wr(OFF_GP0 + 8'(4 * i), {16'h0, GP[i]});
      for (int i = 0; i < 8; i++) begin
         wr(OFF_ACCESS, ACC[i]); wr(OFF_OPERAND, OPD[i]);
         rdc("acc_phys", OFF_ACC_ADDR, PHY[i]);
      end
      rdc("acc_segoff", OFF_ACC_SEGOFF, 32'h4000_0500);
      wr(OFF_ACCESS, 32'h2); wr(OFF_INSTR_CNT, 32'h0100); wr(OFF_ADVANCE, 32'h3);
      rdc("advance", OFF_INSTR_CNT, 32'h0103);
      wr(OFF_BRANCH, 32'h1); wr(OFF_OPERAND, 32'h1000f0); go;
      rdc("rel8", OFF_INSTR_CNT, 32'h00f3);
      wr(OFF_OPERAND, 32'h0200); go;
      rdc("rel16", OFF_INSTR_CNT, 32'h02f3);
      wr(OFF_BRANCH, 32'h52); go;
      rdc("reg_br", OFF_INSTR_CNT, 32'h0300);
      wr(OFF_IMM, 32'h1234_5678); wr(OFF_BRANCH, 32'h0); go;
      rdc("direct", OFF_INSTR_CNT, 32'h5678);
      wr(OFF_MEM_DATA, 32'habcd_4321);
      for (int i = 0; i < 4; i++) begin
         wr(OFF_INSTR_CNT, 32'h0); wr(OFF_BRANCH, BRM[i]); wr(OFF_OPERAND, BOP[i]);
         rdc("ptr_addr", OFF_BR_ADDR, BPA[i]);
         go;
         rdc("mem_br", OFF_INSTR_CNT, 32'h4321);
      end
      rdc("near_cs", OFF_SEG0, 32'h1000);
      for (int s = 0; s < 4; s++) begin
         wr(OFF_REG_SEL, 32'(s * 16 + 11));
         rdc("sel_word", OFF_SEL_VAL, {SEG[s], 16'h0100});
      end
      wr(OFF_REG_SEL, 32'h4);
      rdc("sel_hi", OFF_SEL_VAL, 32'h1000_0012);
      wr(OFF_REG_SEL, 32'h0);
      rdc("sel_lo", OFF_SEL_VAL, 32'h1000_0034);
      wr(OFF_BRANCH, 32'h8); go;
      rdc("far_cs", OFF_SEG0, 32'h1234);
      repeat (2) @(posedge CLK);
      chk("fetch_far", {12'h0, FETCH_ADDR}, 32'h12365);
      wr(OFF_BRANCH, 32'h6b); go;
      rdc("far_ind", OFF_SEG0, 32'habcd);
      wr(OFF_BRANCH, 32'h7); go;
      rdc("br_unused", OFF_INSTR_CNT, 32'h4321);
      wr(OFF_ACCESS, 32'h5);
      rdc("acc_unused", OFF_ACC_ADDR, 32'habcf5);
      xfer(1'b0, 8'h68, 32'h0);
      chk("err_hi", {31'h0, er}, 32'h1);
      xfer(1'b0, 8'h02, 32'h0);
      chk("err_unal", {31'h0, er}, 32'h1);
      wr(OFF_ACC_ADDR, 32'hffff_ffff);
      chk("ro_write", {31'h0, er}, 32'h0);
      @(posedge CLK);
      RST <= 1'b1;
      repeat (3) @(posedge CLK);
      RST <= 1'b0;
      rdc("cnt_rst2", OFF_INSTR_CNT, 32'h0);
      finish_test();
   end
endmodule // tb
